// ### core/sfdpt_pkg.sv
/*
  Constants, field layouts and decode helpers for the read-only
  parameter table block (timing and suspend words).
  Assumes an APB slave consumes it; no clock or reset lives here.
*/
//==============================================================
// Contract
// - chip-erase count 1, 3 or 6 per density
// - chip-erase unit field reads 11b
// - both byte-program time fields read all ones
// - page program 64 us unit, count 00111
// - page size field encodes 256 bytes
// - max page program multiplier reads 0010b
// - suspend/resume support bit 31 reads 0
// - erase suspend latency 8 us unit, count 01001b
// - program suspend latency 8 us unit, count 01001b
// - reserved bit 8 of word twelve reads 1
package sfdpt_pkg;

  // ============================================================
  // register map (byte addresses, one word each)
  localparam logic [11:0] ADDR_WORD11 = 12'h000;
  localparam logic [11:0] ADDR_WORD12 = 12'h004;
  localparam logic [11:0] ADDR_CTRL = 12'h008;
  localparam int CTRL_DENS_LSB = 0;
  localparam int CTRL_WFLAG_BIT = 8;

  // ============================================================
  // density selection
  typedef enum logic [1:0] {
    SFDPT_256M,
    SFDPT_512M,
    SFDPT_1G
  } sfdpt_density_t;
  localparam sfdpt_density_t DENS_RST = SFDPT_256M;

  // ============================================================
  // field values
  localparam logic [4:0] CE_CNT_256M = 5'h01;
  localparam logic [4:0] CE_CNT_512M = 5'h03;
  localparam logic [4:0] CE_CNT_1G = 5'h06;
  localparam logic [1:0] CE_UNIT = 2'h3;
  localparam logic [4:0] BP_UNSPEC = 5'h1F;
  localparam logic PP_UNIT_64US = 1'b1;
  localparam logic [4:0] PP_CNT = 5'h07;
  localparam logic [3:0] PAGE_LOG2 = 4'h8;
  localparam logic [3:0] PP_MAX_MULT = 4'h2;
  localparam logic SUSP_SUPPORT = 1'b0;
  localparam logic [1:0] LAT_UNIT_8US = 2'h2;
  localparam logic [4:0] LAT_CNT = 5'h09;
  localparam logic [3:0] GAP_CNT = 4'h1;
  localparam logic RSV_ONE = 1'b1;
  localparam logic [3:0] ERS_FORBID = 4'hE;
  localparam logic [3:0] PRG_FORBID = 4'hC;

  // ============================================================
  // timing, printed figures and derived cycle counts at pclk
  localparam int CLK_NS = 100;
  localparam int PP_TYP_US = 512;
  localparam int SUSP_LAT_US = 80;
  localparam int GAP_US = 128;
  localparam int GAP_UNIT_US = 64;
  // a longest time rounds down, a least time rounds up
  localparam int SUSP_LAT_CYC = (SUSP_LAT_US * 1000) / CLK_NS;
  localparam int GAP_CYC = (GAP_US * 1000 + CLK_NS - 1) / CLK_NS;

  typedef struct packed {
    logic rsv31;
    logic [1:0] ce_unit;
    logic [4:0] ce_cnt;
    logic [4:0] bp_more;
    logic [4:0] bp_first;
    logic pp_unit;
    logic [4:0] pp_cnt;
    logic [3:0] page_log2;
    logic [3:0] pp_mult;
  } sfdpt_word11_t;

  typedef struct packed {
    logic susp_ok;
    logic [1:0] ers_lat_unit;
    logic [4:0] ers_lat_cnt;
    logic [3:0] ers_gap;
    logic [1:0] prg_lat_unit;
    logic [4:0] prg_lat_cnt;
    logic [3:0] prg_gap;
    logic rsv8;
    logic [3:0] ers_forbid;
    logic [3:0] prg_forbid;
  } sfdpt_word12_t;

  // suspend latency in ns from unit code and count
  function automatic int sfdpt_lat_ns(input logic [1:0] u,
                                      input logic [4:0] c);
    int unit_ns;
    case (u)
      2'h0: unit_ns = 128;
      2'h1: unit_ns = 1000;
      2'h2: unit_ns = 8000;
      default: unit_ns = 64000;
    endcase
    return (int'(c) + 1) * unit_ns;
  endfunction

  // page program typical time in us
  function automatic int sfdpt_pp_us(input logic u,
                                     input logic [4:0] c);
    return (int'(c) + 1) * (u ? 64 : 8);
  endfunction

endpackage

// ### core/sfdpt_table.sv
/*
  APB slave presenting the timing/suspend parameter words and a
  density select register.
  Assumes a single pclk domain and an APB master on the same clock.
*/
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
module sfdpt_table (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // ============================================================
  // state
  sfdpt_pkg::sfdpt_density_t density;
  sfdpt_pkg::sfdpt_density_t next_density;
  logic wflag;
  logic next_wflag;
  logic [31:0] next_prdata;
  sfdpt_pkg::sfdpt_word11_t word11;
  sfdpt_pkg::sfdpt_word12_t word12;
  logic setup;
  logic access;
  logic hit_tab;
  logic hit_ctrl;
  logic tab_wr;
  logic [1:0] wdens;

  assign setup = psel && !penable;
  assign access = psel && penable;

  // ============================================================
  // table contents, fixed except for the density count
  always_comb begin
    word11.rsv31 = sfdpt_pkg::RSV_ONE;
    word11.ce_unit = sfdpt_pkg::CE_UNIT;
    case (density)
      sfdpt_pkg::SFDPT_512M: word11.ce_cnt = sfdpt_pkg::CE_CNT_512M;
      sfdpt_pkg::SFDPT_1G: word11.ce_cnt = sfdpt_pkg::CE_CNT_1G;
      default: word11.ce_cnt = sfdpt_pkg::CE_CNT_256M;
    endcase
    word11.bp_more = sfdpt_pkg::BP_UNSPEC;
    word11.bp_first = sfdpt_pkg::BP_UNSPEC;
    word11.pp_unit = sfdpt_pkg::PP_UNIT_64US;
    word11.pp_cnt = sfdpt_pkg::PP_CNT;
    word11.page_log2 = sfdpt_pkg::PAGE_LOG2;
    word11.pp_mult = sfdpt_pkg::PP_MAX_MULT;
  end

  // suspend word never depends on density
  always_comb begin
    word12.susp_ok = sfdpt_pkg::SUSP_SUPPORT;
    word12.ers_lat_unit = sfdpt_pkg::LAT_UNIT_8US;
    word12.ers_lat_cnt = sfdpt_pkg::LAT_CNT;
    word12.ers_gap = sfdpt_pkg::GAP_CNT;
    word12.prg_lat_unit = sfdpt_pkg::LAT_UNIT_8US;
    word12.prg_lat_cnt = sfdpt_pkg::LAT_CNT;
    word12.prg_gap = sfdpt_pkg::GAP_CNT;
    word12.rsv8 = sfdpt_pkg::RSV_ONE;
    word12.ers_forbid = sfdpt_pkg::ERS_FORBID;
    word12.prg_forbid = sfdpt_pkg::PRG_FORBID;
  end

  // ============================================================
  // address decode
  always_comb begin
    hit_tab = 1'b0;
    hit_ctrl = 1'b0;
    if (paddr == sfdpt_pkg::ADDR_WORD11) begin
      hit_tab = 1'b1;
    end else if (paddr == sfdpt_pkg::ADDR_WORD12) begin
      hit_tab = 1'b1;
    end else if (paddr == sfdpt_pkg::ADDR_CTRL) begin
      hit_ctrl = 1'b1;
    end
  end

  // zero wait states; table writes and unmapped hits report error
  assign pready = 1'b1;
  assign pslverr = access && (!(hit_tab || hit_ctrl) ||
                              (pwrite && hit_tab));
  assign tab_wr = access && pwrite && hit_tab;
  assign wdens = pwdata[sfdpt_pkg::CTRL_DENS_LSB +: 2];

  // ============================================================
  // next values; read data is loaded in setup so it is a flop
  always_comb begin
    next_density = density;
    next_wflag = wflag;
    next_prdata = prdata;
    // density code 3 is not a part, so such a write is dropped
    if (access && pwrite && hit_ctrl && pstrb[0] &&
        wdens != 2'h3) begin
      next_density = sfdpt_pkg::sfdpt_density_t'(wdens);
    end
    // sticky flag: write one clears, a new attempt wins
    if (access && pwrite && hit_ctrl && pstrb[1] &&
        pwdata[sfdpt_pkg::CTRL_WFLAG_BIT]) begin
      next_wflag = 1'b0;
    end
    if (tab_wr) begin
      next_wflag = 1'b1;
    end
    if (setup && !pwrite) begin
      if (paddr == sfdpt_pkg::ADDR_WORD11) begin
        next_prdata = word11;
      end else if (paddr == sfdpt_pkg::ADDR_WORD12) begin
        next_prdata = word12;
      end else if (paddr == sfdpt_pkg::ADDR_CTRL) begin
        next_prdata = 32'h0000_0000;
        next_prdata[sfdpt_pkg::CTRL_DENS_LSB +: 2] = density;
        next_prdata[sfdpt_pkg::CTRL_WFLAG_BIT] = wflag;
      end else begin
        next_prdata = 32'h0000_0000;
      end
    end
  end

  // registers only; table words themselves have no storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      density <= sfdpt_pkg::DENS_RST;
      wflag <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      density <= next_density;
      wflag <= next_wflag;
      prdata <= next_prdata;
    end
  end

  // ============================================================
  // checks on read data returned in the access phase, on table write refusal and on density hold
  logic rd11;
  logic rd12;
  assign rd11 = access && !pwrite && paddr == sfdpt_pkg::ADDR_WORD11;
  assign rd12 = access && !pwrite && paddr == sfdpt_pkg::ADDR_WORD12;

  a_ce_count: assert property (
    @(posedge pclk) disable iff (!presetn)
    rd11 |-> prdata[28:24] == (density == sfdpt_pkg::SFDPT_1G ? 5'h06 :
      density == sfdpt_pkg::SFDPT_512M ? 5'h03 : 5'h01))
    else $error("chip erase count wrong for density");

  a_ce_unit: assert property (
    @(posedge pclk) disable iff (!presetn)
    rd11 |-> prdata[30:29] == 2'h3)
    else $error("chip erase unit not 11b");

  a_byte_prog: assert property (
    @(posedge pclk) disable iff (!presetn)
    rd11 |-> prdata[23:14] == 10'h3FF)
    else $error("byte program fields not all ones");

  a_page_prog: assert property (
    @(posedge pclk) disable iff (!presetn)
    rd11 |-> sfdpt_pkg::sfdpt_pp_us(prdata[13], prdata[12:8]) ==
      sfdpt_pkg::PP_TYP_US)
    else $error("page program time not 512 us");

  a_page_size: assert property (
    @(posedge pclk) disable iff (!presetn)
    rd11 |-> (32'h1 << prdata[7:4]) == 32'h100)
    else $error("page size not 256 bytes");

  a_max_mult: assert property (
    @(posedge pclk) disable iff (!presetn)
    rd11 |-> prdata[3:0] == 4'h2)
    else $error("max program multiplier not 0010b");

  a_susp_bit: assert property (
    @(posedge pclk) disable iff (!presetn)
    rd12 |-> !prdata[31])
    else $error("suspend support bit not zero");

  a_erase_lat: assert property (
    @(posedge pclk) disable iff (!presetn)
    rd12 |-> sfdpt_pkg::sfdpt_lat_ns(prdata[30:29], prdata[28:24])
      == sfdpt_pkg::SUSP_LAT_US * 1000)
    else $error("erase suspend latency not 80 us");

  a_prog_lat: assert property (
    @(posedge pclk) disable iff (!presetn)
    rd12 |-> sfdpt_pkg::sfdpt_lat_ns(prdata[19:18], prdata[17:13])
      == sfdpt_pkg::SUSP_LAT_US * 1000 &&
      (int'(prdata[23:20]) + 1) * sfdpt_pkg::GAP_UNIT_US ==
      sfdpt_pkg::GAP_US &&
      (int'(prdata[12:9]) + 1) * sfdpt_pkg::GAP_UNIT_US ==
      sfdpt_pkg::GAP_US)
    else $error("program latency or resume gap wrong");

  a_rsv_bit: assert property (
    @(posedge pclk) disable iff (!presetn)
    rd12 |-> prdata[8] && prdata[7:0] == 8'hEC)
    else $error("reserved bit or restriction fields wrong");

  a_table_ro: assert property (
    @(posedge pclk) disable iff (!presetn)
    tab_wr |-> pslverr ##1 ($stable(density) && wflag))
    else $error("table write was not refused");

  a_dens_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    !(access && pwrite && hit_ctrl) |=> $stable(density))
    else $error("density changed without a control write");

  // ============================================================
  // bus behaviour: ready, error response and read data timing
  logic ctrl_wr;
  logic rd_setup;
  logic unmapped;
  assign ctrl_wr = access && pwrite && hit_ctrl;
  assign rd_setup = setup && !pwrite;
  assign unmapped = !(hit_tab || hit_ctrl);

  // ready is tied high, so a master never waits
  a_ready_high: assert property (
    @(posedge pclk) disable iff (!presetn)
    pready)
    else $error("ready dropped although no wait states exist");

  // error is only meaningful while the access phase stands
  a_err_access: assert property (
    @(posedge pclk) disable iff (!presetn)
    pslverr |-> access)
    else $error("error response outside the access phase");

  a_unmap_err: assert property (
    @(posedge pclk) disable iff (!presetn)
    access && unmapped |-> pslverr)
    else $error("unmapped access not refused");

  // legal accesses must never be refused, or software retries forever
  a_ctrl_ok: assert property (
    @(posedge pclk) disable iff (!presetn)
    access && hit_ctrl |-> !pslverr)
    else $error("control access refused");

  a_tab_read_ok: assert property (
    @(posedge pclk) disable iff (!presetn)
    access && !pwrite && hit_tab |-> !pslverr)
    else $error("table read refused");

  // read data is loaded in setup, so check it one edge later
  a_unmap_data: assert property (
    @(posedge pclk) disable iff (!presetn)
    rd_setup && unmapped |=> prdata == 32'h0000_0000)
    else $error("unmapped read data not zero");

  a_ctrl_data: assert property (
    @(posedge pclk) disable iff (!presetn)
    rd_setup && hit_ctrl |=>
      prdata[sfdpt_pkg::CTRL_DENS_LSB +: 2] == density &&
      prdata[sfdpt_pkg::CTRL_WFLAG_BIT] == wflag &&
      prdata[31:9] == 23'h00_0000 && prdata[7:2] == 6'h00)
    else $error("control read data wrong");

  // read data stands until the next read setup cycle
  a_rd_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    !rd_setup |=> $stable(prdata))
    else $error("read data changed outside a read setup");

  // ============================================================
  // control register: density select and sticky write flag
  // every refused table write must leave a trace for software
  a_flag_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    tab_wr |=> wflag)
    else $error("table write attempt not flagged");

  a_flag_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    ctrl_wr && pstrb[1] && pwdata[sfdpt_pkg::CTRL_WFLAG_BIT]
      |=> !wflag)
    else $error("write one did not clear the flag");

  a_flag_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    !(ctrl_wr || tab_wr) |=> $stable(wflag))
    else $error("flag changed without a write");

  a_dens_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    ctrl_wr && pstrb[0] && wdens != 2'h3 |=> density == $past(wdens))
    else $error("density write did not land");

  // an unusable code must not leave the count field undefined
  a_dens_code3: assert property (
    @(posedge pclk) disable iff (!presetn)
    ctrl_wr && (!pstrb[0] || wdens == 2'h3) |=> $stable(density))
    else $error("density moved on a dropped write");

  a_dens_legal: assert property (
    @(posedge pclk) disable iff (!presetn)
    density inside {sfdpt_pkg::SFDPT_256M, sfdpt_pkg::SFDPT_512M,
      sfdpt_pkg::SFDPT_1G})
    else $error("density holds a code that names no part");

endmodule

// ### test/sfdpt_host.sv
/*
  Host controller model: an APB master that reads the parameter words.
  Assumes one pclk domain shared with the table it reads.
*/
`timescale 1ns/10ps
module sfdpt_host (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  //==========================================================
  // idle bus
  logic hung;
  initial begin
    hung = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    pstrb = 4'h0;
  end

  //==========================================================
  // one transfer; only table accesses are made, so this host never
  // starts, suspends or resumes any flash operation
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // bounded wait so a dead slave cannot hang the run
    for (n = 0; n < 16; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 16) hung = 1'b1;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// ### test/sfdpt_table_tb.sv
/*
  Self-checking bench for the parameter table block.
  Assumes the host model drives the APB side of the table.
*/
`timescale 1ns/10ps
module sfdpt_table_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  int bad_count = 0;
  int checks_done = 0;
  // word twelve as the suspend fields spell it out
  localparam logic [31:0] W12 = {1'h0, 2'h2, 5'h09, 4'h1, 2'h2,
    5'h09, 4'h1, 1'h1, 4'hE, 4'hC};

  sfdpt_table dut_u (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr);
  sfdpt_host host_u (.pclk, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr);

  //==========================================================
  // clock and helpers
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  function automatic logic [31:0] w11(input logic [4:0] ce);
    return {1'h1, 2'h3, ce, 5'h1F, 5'h1F, 1'h1, 5'h07, 4'h8, 4'h2};
  endfunction

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic cmp32(input string nm, input logic [31:0] e);
    checks_done++;
    if (rd !== e) begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", nm, e, rd);
    end
  endtask

  task automatic cmp_err(input string nm, input logic e);
    checks_done++;
    if (err !== e) begin
      bad_count++;
      $display("[ERR] %s exp %b got %b", nm, e, err);
    end
  endtask

  // a hung transfer counts as a mismatch and ends the run
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    host_u.xfer(w, a, d, s, rd, err);
    if (host_u.hung) begin
      bad_count++;
      complete_run();
    end
  endtask

  //==========================================================
  // scenarios
  task automatic t_reset();
    bus(1'b0, 12'h008, 32'h0, 4'h0);
    cmp32("ctrl", 32'h00000000);
    bus(1'b0, 12'h000, 32'h0, 4'h0);
    cmp32("word11", w11(5'h01));
    bus(1'b0, 12'h004, 32'h0, 4'h0);
    cmp32("word12", W12);
    $display("test reset done");
  endtask

  task automatic t_density();
    logic [4:0] ce [3] = '{5'h01, 5'h03, 5'h06};
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, 12'h008, 32'(i), 4'h1);
      cmp_err("ctrl wr", 1'b0);
      bus(1'b0, 12'h000, 32'h0, 4'h0);
      cmp32("word11", w11(ce[i]));
      bus(1'b0, 12'h004, 32'h0, 4'h0);
      cmp32("word12", W12);
    end
    // code 3 names no density and is dropped
    bus(1'b1, 12'h008, 32'h00000003, 4'h1);
    bus(1'b0, 12'h008, 32'h0, 4'h0);
    cmp32("ctrl", 32'h00000002);
    $display("test density done");
  endtask

  task automatic t_read_only();
    bus(1'b1, 12'h000, 32'h00000000, 4'hF);
    cmp_err("wr word11", 1'b1);
    bus(1'b1, 12'h004, 32'hFFFFFFFF, 4'hF);
    cmp_err("wr word12", 1'b1);
    bus(1'b0, 12'h000, 32'h0, 4'h0);
    cmp32("word11", w11(5'h06));
    bus(1'b0, 12'h004, 32'h0, 4'h0);
    cmp32("word12", W12);
    bus(1'b0, 12'h008, 32'h0, 4'h0);
    cmp32("ctrl flag", 32'h00000102);
    // lane 0 off: density must survive the flag clear
    bus(1'b1, 12'h008, 32'h00000100, 4'h2);
    bus(1'b0, 12'h008, 32'h0, 4'h0);
    cmp32("ctrl clr", 32'h00000002);
    $display("test read only done");
  endtask

  task automatic t_unmapped();
    bus(1'b0, 12'h00C, 32'h0, 4'h0);
    cmp_err("rd unmapped", 1'b1);
    cmp32("rd unmapped", 32'h00000000);
    bus(1'b1, 12'h00C, 32'h00000001, 4'hF);
    cmp_err("wr unmapped", 1'b1);
    bus(1'b0, 12'h008, 32'h0, 4'h0);
    cmp32("ctrl", 32'h00000002);
    $display("test unmapped done");
  endtask

  // reset in mid-run: density and flag must fall back
  task automatic t_reset_mid();
    bus(1'b1, 12'h000, 32'h0, 4'hF);
    cmp_err("wr word11", 1'b1);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    bus(1'b0, 12'h008, 32'h0, 4'h0);
    cmp32("ctrl after rst", 32'h00000000);
    bus(1'b0, 12'h000, 32'h0, 4'h0);
    cmp32("word11 after rst", w11(5'h01));
    $display("test reset mid done");
  endtask

  //==========================================================
  // main sequence and watchdog
  initial begin
    presetn = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_density();
    t_read_only();
    t_unmapped();
    t_reset_mid();
    complete_run();
  end

  initial begin
    #2000000;
    bad_count++;
    complete_run();
  end
endmodule
